// *** rtl/cache_policy_pkg.sv ***
// Constants, field positions and types for the cache policy register bank
// Assumes use through explicit package scope, never imported
package cache_policy_pkg;

  localparam int unsigned DATA_W   = 64;
  localparam int unsigned CFG_W    = 32;
  localparam int unsigned THRESH_W = 13;
  localparam int unsigned DIST_W   = 6;

  typedef enum logic [2:0] {
    SEL_AUX = 3'h1,
    SEL_CFG = 3'h2,
    SEL_EXT = 3'h4
  } reg_sel_e;

  localparam logic [1:0] EL0 = 2'h0;
  localparam logic [1:0] EL1 = 2'h1;
  localparam logic [1:0] EL2 = 2'h2;
  localparam logic [1:0] EL3 = 2'h3;

  // Configuration register layout
  localparam int unsigned CFG_SCU_BIT  = 2;
  localparam int unsigned CFG_ECC_LSB  = 0;
  localparam logic        SCU_PRESENT  = 1'h0;
  localparam logic [1:0]  ECC_ABSENT   = 2'h0;
  localparam logic [1:0]  ECC_PRESENT  = 2'h1;

  // Extended control layout
  localparam int unsigned ATOMIC_PLACEMENT_LSB   = 38;
  localparam int unsigned FLUSH_BIT  = 37;
  localparam int unsigned L3WS_LSB   = 29;
  localparam int unsigned L2WS_LSB   = 27;
  localparam int unsigned L1WS_LSB   = 25;
  localparam int unsigned L1P_LSB    = 13;
  localparam int unsigned L3P_LSB    = 10;
  localparam int unsigned EXTERNAL_LAST_LEVEL_CACHE_BIT = 0;

  localparam logic [63:0] EXT_WR_MASK = 64'h0000_00e0_7e00_fc01;
  localparam logic [63:0] EXT_RESET   = 64'h0000_0000_2800_bc00;
  localparam logic [63:0] AUX_RESET   = 64'h0;

  localparam logic [1:0] ATOMIC_PLACEMENT_HIT_UNIQUE = 2'h0;
  localparam logic [1:0] ATOMIC_PLACEMENT_ALL_NEAR   = 2'h1;
  localparam logic [1:0] ATOMIC_PLACEMENT_FAR        = 2'h2;
  localparam logic [1:0] ATOMIC_PLACEMENT_LOAD_NEAR  = 2'h3;

  localparam logic [1:0] STREAM_OFF = 2'h3;

  localparam logic [THRESH_W-1:0] L3_T0 = 13'h0080;
  localparam logic [THRESH_W-1:0] L3_T1 = 13'h0400;
  localparam logic [THRESH_W-1:0] L3_T2 = 13'h1000;
  localparam logic [THRESH_W-1:0] L2_T0 = 13'h0010;
  localparam logic [THRESH_W-1:0] L2_T1 = 13'h0080;
  localparam logic [THRESH_W-1:0] L2_T2 = 13'h0200;
  localparam logic [THRESH_W-1:0] L1_T0 = 13'h0004;
  localparam logic [THRESH_W-1:0] L1_T1 = 13'h0040;
  localparam logic [THRESH_W-1:0] L1_T2 = 13'h0080;

  localparam logic [2:0] DIST_16  = 3'h0;
  localparam logic [2:0] DIST_32  = 3'h1;
  localparam logic [2:0] DIST_RV0 = 3'h2;
  localparam logic [2:0] DIST_RV1 = 3'h3;
  localparam logic [2:0] DIST_OFF = 3'h4;
  localparam logic [2:0] DIST_2   = 3'h5;
  localparam logic [2:0] DIST_4   = 3'h6;
  localparam logic [2:0] DIST_8   = 3'h7;

endpackage

// *** rtl/access_check_if.sv ***
// Carries one register access between the bank and its permission check
// Assumes both ends sit in the same clock domain
`timescale 1ns/10ps
interface access_check_if;
  logic [1:0]                  el;
  logic                        secure;
  logic                        write;
  cache_policy_pkg::reg_sel_e  target;
  logic                        el2AuxBit;
  logic                        el3AuxBit;
  logic                        permit;

  modport bank  (output el, output secure, output write, output target,
                 output el2AuxBit, output el3AuxBit, input permit);
  modport check (input el, input secure, input write, input target,
                 input el2AuxBit, input el3AuxBit, output permit);
endinterface

// *** rtl/access_gate.sv ***
// Permission check for coprocessor transfers into the register bank
// Assumes the access-control bits come from logic on the same clock
`timescale 1ns/10ps
module access_gate (
  access_check_if.check acc
);

  always_comb begin
    acc.permit = 1'b0;
    if (acc.el == cache_policy_pkg::EL0) begin
      acc.permit = 1'b0;
    end else if (acc.target == cache_policy_pkg::SEL_CFG) begin
      acc.permit = !acc.write;
    end else if (acc.target == cache_policy_pkg::SEL_EXT) begin
      acc.permit = 1'b1;
    end else if (acc.target == cache_policy_pkg::SEL_AUX) begin
      if (!acc.write || acc.el == cache_policy_pkg::EL3) begin
        acc.permit = 1'b1;
      end else if (acc.el == cache_policy_pkg::EL2) begin
        acc.permit = acc.el3AuxBit;
      end else begin
        // Non-secure EL1 also needs the hypervisor level to allow it
        acc.permit = acc.el3AuxBit && (acc.secure || acc.el2AuxBit);
      end
    end
  end

endmodule

// *** rtl/core_aux_cache_policy_regs.sv ***
// Auxiliary, configuration and extended cache-control registers of a core
// Assumes one request per cycle at most, from logic on the core clock
// Summary of operation
// - Auxiliary control is 64 bits, all implementer-reserved, stored as written.
// - One auxiliary control copy serves secure and non-secure states alike.
// - EL1 and EL2 writes to auxiliary control gated by higher bit 0.
// - Configuration register is 32 bits read-only; bits 31:3 read zero.
// - Configuration bit 2 reads 0: snoop control unit present.
// - Configuration bits 1:0 report error correction: 0 absent, 1 present.
// - Extended control is 64 bits; 63:40, 36:31, 24:16, 9:1 reserved zero.
// - Placement 00: cacheable atomic near on unique hit, else far.
// - Placement 01 forces all atomics near; 10 sends them far.
// - Placement 11: load atomics near; store atomics use hit-unique rule.
// - Flush bit 0: flushed clean lines allocate into L3.
// - Flush bit 1: clean lines neither supply data nor allocate; evict notify.
// - Bits 30:29 set no-L3-allocate streaming threshold 128/1024/4096/off.
// - Bits 28:27 set no-L1/L2-allocate threshold 16/128/512/off.
// - Bits 26:25 set no-L1-allocate threshold 4/64/128/off.
// - Bits 15:13 cap outstanding hardware L1 prefetches, reset five.
// - Bits 12:10 set how far L3 prefetch requests run ahead.
// - Distance codes 16,32,off,2,4,8 lines; codes 010/011 reserved.
// - Bit 0 resets 0; 1 marks an external last-level cache.
`timescale 1ns/10ps
module core_aux_cache_policy_regs #(
  parameter logic [1:0] ECC_CODE = cache_policy_pkg::ECC_ABSENT
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        reqValid,
  input  wire logic                        reqWrite,
  input  wire cache_policy_pkg::reg_sel_e  reqTarget,
  input  wire logic [1:0]                  reqEl,
  input  wire logic                        reqSecure,
  input  wire logic [63:0]                 reqWdata,
  input  wire logic                        el2AuxBit,
  input  wire logic                        el3AuxBit,
  output logic                             ackQ,
  output logic                             faultQ,
  output logic [63:0]                      rdataQ,
  input  wire logic                        atomReq,
  input  wire logic                        atomLoad,
  input  wire logic                        atomHitUnique,
  output logic                             atomDoneQ,
  output logic                             atomNearQ,
  output logic                             flushAllocL3Q,
  output logic                             flushSupplyDataQ,
  output logic                             flushEvictNotifyQ,
  output logic [12:0]                      l3StreamThreshQ,
  output logic                             l3StreamEnQ,
  output logic [12:0]                      l2StreamThreshQ,
  output logic                             l2StreamEnQ,
  output logic [12:0]                      l1StreamThreshQ,
  output logic                             l1StreamEnQ,
  output logic [2:0]                       nearPrefetchLimitQ,
  output logic [5:0]                       farPrefetchLinesQ,
  output logic                             farPrefetchEnQ,
  output logic                             externalLlcQ
);

  logic                 rstSync1_q;
  logic                 rstSync2_q;
  logic                 rstN;
  logic [63:0]          auxControl_q;
  logic [63:0]          extCtl_q;
  logic [63:0]          extCtl_d;
  logic [31:0]          cfgValue;
  logic [63:0]          readValue;
  logic                 wrAux;
  logic                 wrExt;
  logic [1:0]           atomField;
  logic [1:0]           l3Field;
  logic [1:0]           l2Field;
  logic [1:0]           l1Field;
  logic [2:0]           distField;

  access_check_if acc ();

  // Reset is released through two flops so its removal is synchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rstN = rstSync2_q;

  assign acc.el        = reqEl;
  assign acc.secure    = reqSecure;
  assign acc.write     = reqWrite;
  assign acc.target    = reqTarget;
  assign acc.el2AuxBit = el2AuxBit;
  assign acc.el3AuxBit = el3AuxBit;

  access_gate gate (
    .acc (acc.check)
  );

  function automatic logic [12:0] streamThresh(
    input logic [1:0]  code,
    input logic [12:0] t0,
    input logic [12:0] t1,
    input logic [12:0] t2
  );
    logic [12:0] r;
    r = 13'h0;
    case (code)
      2'h0:    r = t0;
      2'h1:    r = t1;
      2'h2:    r = t2;
      default: r = 13'h0;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] distLines(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h0;
    case (code)
      cache_policy_pkg::DIST_16: r = 6'h10;
      cache_policy_pkg::DIST_32: r = 6'h20;
      cache_policy_pkg::DIST_2:  r = 6'h02;
      cache_policy_pkg::DIST_4:  r = 6'h04;
      cache_policy_pkg::DIST_8:  r = 6'h08;
      default:                   r = 6'h00;
    endcase
    return r;
  endfunction

  assign atomField = extCtl_q[cache_policy_pkg::ATOMIC_PLACEMENT_LSB +: 2];
  assign l3Field   = extCtl_q[cache_policy_pkg::L3WS_LSB +: 2];
  assign l2Field   = extCtl_q[cache_policy_pkg::L2WS_LSB +: 2];
  assign l1Field   = extCtl_q[cache_policy_pkg::L1WS_LSB +: 2];
  assign distField = extCtl_q[cache_policy_pkg::L3P_LSB +: 3];

  assign wrAux = reqValid && reqWrite && acc.permit
              && reqTarget == cache_policy_pkg::SEL_AUX;
  assign wrExt = reqValid && reqWrite && acc.permit
              && reqTarget == cache_policy_pkg::SEL_EXT;

  // Fixed configuration word; upper bits are constant zero
  always_comb begin
    cfgValue = 32'h0;
    cfgValue[cache_policy_pkg::CFG_SCU_BIT] =
      cache_policy_pkg::SCU_PRESENT;
    cfgValue[cache_policy_pkg::CFG_ECC_LSB +: 2] = ECC_CODE;
  end

  // Reserved distance codes leave the old field in place rather than
  // letting the prefetcher see an undefined distance
  always_comb begin
    extCtl_d = reqWdata & cache_policy_pkg::EXT_WR_MASK;
    if (reqWdata[cache_policy_pkg::L3P_LSB +: 3]
          == cache_policy_pkg::DIST_RV0
        || reqWdata[cache_policy_pkg::L3P_LSB +: 3]
          == cache_policy_pkg::DIST_RV1) begin
      extCtl_d[cache_policy_pkg::L3P_LSB +: 3] = distField;
    end
  end

  // No security-state index: both worlds share this copy
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      auxControl_q <= cache_policy_pkg::AUX_RESET;
    end else if (wrAux) begin
      auxControl_q <= reqWdata;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      extCtl_q <= cache_policy_pkg::EXT_RESET;
    end else if (wrExt) begin
      extCtl_q <= extCtl_d;
    end
  end

  always_comb begin
    readValue = 64'h0;
    if (reqTarget == cache_policy_pkg::SEL_AUX) begin
      readValue = auxControl_q;
    end else if (reqTarget == cache_policy_pkg::SEL_CFG) begin
      readValue = {32'h0, cfgValue};
    end else if (reqTarget == cache_policy_pkg::SEL_EXT) begin
      readValue = extCtl_q & cache_policy_pkg::EXT_WR_MASK;
    end
  end

  // Answer one cycle after the request; a refused access returns zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ackQ   <= 1'b0;
      faultQ <= 1'b0;
      rdataQ <= 64'h0;
    end else begin
      ackQ   <= reqValid;
      faultQ <= reqValid && !acc.permit;
      if (reqValid && !reqWrite && acc.permit) begin
        rdataQ <= readValue;
      end else begin
        rdataQ <= 64'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      atomDoneQ <= 1'b0;
      atomNearQ <= 1'b0;
    end else begin
      atomDoneQ <= atomReq;
      case (atomField)
        cache_policy_pkg::ATOMIC_PLACEMENT_ALL_NEAR:  atomNearQ <= 1'b1;
        cache_policy_pkg::ATOMIC_PLACEMENT_FAR:       atomNearQ <= 1'b0;
        cache_policy_pkg::ATOMIC_PLACEMENT_LOAD_NEAR: begin
          atomNearQ <= atomLoad || atomHitUnique;
        end
        default:                          atomNearQ <= atomHitUnique;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flushAllocL3Q     <= 1'b0;
      flushSupplyDataQ  <= 1'b0;
      flushEvictNotifyQ <= 1'b0;
    end else begin
      flushAllocL3Q     <= !extCtl_q[cache_policy_pkg::FLUSH_BIT];
      flushSupplyDataQ  <= !extCtl_q[cache_policy_pkg::FLUSH_BIT];
      flushEvictNotifyQ <= extCtl_q[cache_policy_pkg::FLUSH_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      l3StreamThreshQ <= 13'h0;
      l3StreamEnQ     <= 1'b0;
      l2StreamThreshQ <= 13'h0;
      l2StreamEnQ     <= 1'b0;
      l1StreamThreshQ <= 13'h0;
      l1StreamEnQ     <= 1'b0;
    end else begin
      l3StreamThreshQ <= streamThresh(l3Field, cache_policy_pkg::L3_T0,
        cache_policy_pkg::L3_T1, cache_policy_pkg::L3_T2);
      l3StreamEnQ     <= l3Field != cache_policy_pkg::STREAM_OFF;
      l2StreamThreshQ <= streamThresh(l2Field, cache_policy_pkg::L2_T0,
        cache_policy_pkg::L2_T1, cache_policy_pkg::L2_T2);
      l2StreamEnQ     <= l2Field != cache_policy_pkg::STREAM_OFF;
      l1StreamThreshQ <= streamThresh(l1Field, cache_policy_pkg::L1_T0,
        cache_policy_pkg::L1_T1, cache_policy_pkg::L1_T2);
      l1StreamEnQ     <= l1Field != cache_policy_pkg::STREAM_OFF;
    end
  end

  // Limit counts hardware prefetches only; software ones bypass it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      nearPrefetchLimitQ <= 3'h0;
      farPrefetchLinesQ  <= 6'h0;
      farPrefetchEnQ     <= 1'b0;
      externalLlcQ       <= 1'b0;
    end else begin
      nearPrefetchLimitQ <= extCtl_q[cache_policy_pkg::L1P_LSB +: 3];
      farPrefetchLinesQ  <= distLines(distField);
      farPrefetchEnQ     <= distField != cache_policy_pkg::DIST_OFF;
      externalLlcQ       <= extCtl_q[cache_policy_pkg::EXTERNAL_LAST_LEVEL_CACHE_BIT];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  sequence cfgReadReq;
    reqValid && !reqWrite && reqTarget == cache_policy_pkg::SEL_CFG
      && reqEl != cache_policy_pkg::EL0;
  endsequence

  sequence auxBlockedWr;
    reqValid && reqWrite && reqTarget == cache_policy_pkg::SEL_AUX
      && reqEl == cache_policy_pkg::EL2 && !el3AuxBit;
  endsequence

  cfg_read_a: assert property (cfgReadReq |=> ackQ && !faultQ
      && rdataQ == {61'h0, cache_policy_pkg::SCU_PRESENT, ECC_CODE})
    else $error("configuration read value wrong");

  cfg_readonly_a: assert property (reqValid && reqWrite
      && reqTarget == cache_policy_pkg::SEL_CFG |=> ackQ && faultQ)
    else $error("configuration write not refused");

  aux_block_a: assert property (auxBlockedWr |=> faultQ
      && $stable(auxControl_q))
    else $error("blocked auxiliary write took effect");

  aux_shared_a: assert property (reqValid && reqWrite
      && reqTarget == cache_policy_pkg::SEL_AUX
      && reqEl == cache_policy_pkg::EL3 |=> auxControl_q == $past(reqWdata))
    else $error("auxiliary write from top level lost");

  ext_res0_a: assert property ((extCtl_q
      & ~cache_policy_pkg::EXT_WR_MASK) == 64'h0)
    else $error("reserved extended bits set");

  atomic_placement_far_a: assert property (atomField == cache_policy_pkg::ATOMIC_PLACEMENT_FAR
      ##1 atomField == cache_policy_pkg::ATOMIC_PLACEMENT_FAR |-> !atomNearQ)
    else $error("far placement executed near");

  atomic_placement_load_a: assert property (atomField
      == cache_policy_pkg::ATOMIC_PLACEMENT_LOAD_NEAR && atomLoad |=> atomNearQ)
    else $error("load atomic not near");

  atomic_placement_default_a: assert property (atomField
      == cache_policy_pkg::ATOMIC_PLACEMENT_HIT_UNIQUE |=> atomNearQ == $past(atomHitUnique))
    else $error("default placement wrong");

  l3_thresh_a: assert property (l3Field == 2'h1 |=>
      l3StreamThreshQ == cache_policy_pkg::L3_T1 && l3StreamEnQ)
    else $error("L3 stream threshold wrong");

  flush_pol_a: assert property (extCtl_q[cache_policy_pkg::FLUSH_BIT]
      |=> flushEvictNotifyQ && !flushAllocL3Q && !flushSupplyDataQ)
    else $error("flush policy outputs wrong");

endmodule

// *** verification/core_aux_cache_policy_regs_bench.sv ***
// Self-checking bench for the cache policy register bank
// Assumes one access or atomic query at a time, answered one cycle later
`timescale 1ns/10ps
module core_aux_cache_policy_regs_bench;
  logic                       clk;
  logic                       rst_b;
  logic                       reqValid;
  logic                       reqWrite;
  cache_policy_pkg::reg_sel_e reqTarget;
  logic [1:0]                 reqEl;
  logic                       reqSecure;
  logic [63:0]                reqWdata;
  logic                       el2AuxBit;
  logic                       el3AuxBit;
  logic                       ackQ;
  logic                       faultQ;
  logic [63:0]                rdataQ;
  logic                       atomReq;
  logic                       atomLoad;
  logic                       atomHitUnique;
  logic                       atomDoneQ;
  logic                       atomNearQ;
  logic                       flushAllocL3Q;
  logic                       flushSupplyDataQ;
  logic                       flushEvictNotifyQ;
  logic [12:0]                l3StreamThreshQ;
  logic                       l3StreamEnQ;
  logic [12:0]                l2StreamThreshQ;
  logic                       l2StreamEnQ;
  logic [12:0]                l1StreamThreshQ;
  logic                       l1StreamEnQ;
  logic [2:0]                 nearPrefetchLimitQ;
  logic [5:0]                 farPrefetchLinesQ;
  logic                       farPrefetchEnQ;
  logic                       externalLlcQ;
  int                         nErrors;
  int                         checkCount;

  core_aux_cache_policy_regs u_core_aux_cache_policy_regs (
    .clk                (clk),
    .rst_b              (rst_b),
    .reqValid           (reqValid),
    .reqWrite           (reqWrite),
    .reqTarget          (reqTarget),
    .reqEl              (reqEl),
    .reqSecure          (reqSecure),
    .reqWdata           (reqWdata),
    .el2AuxBit          (el2AuxBit),
    .el3AuxBit          (el3AuxBit),
    .ackQ               (ackQ),
    .faultQ             (faultQ),
    .rdataQ             (rdataQ),
    .atomReq            (atomReq),
    .atomLoad           (atomLoad),
    .atomHitUnique      (atomHitUnique),
    .atomDoneQ          (atomDoneQ),
    .atomNearQ          (atomNearQ),
    .flushAllocL3Q      (flushAllocL3Q),
    .flushSupplyDataQ   (flushSupplyDataQ),
    .flushEvictNotifyQ  (flushEvictNotifyQ),
    .l3StreamThreshQ    (l3StreamThreshQ),
    .l3StreamEnQ        (l3StreamEnQ),
    .l2StreamThreshQ    (l2StreamThreshQ),
    .l2StreamEnQ        (l2StreamEnQ),
    .l1StreamThreshQ    (l1StreamThreshQ),
    .l1StreamEnQ        (l1StreamEnQ),
    .nearPrefetchLimitQ (nearPrefetchLimitQ),
    .farPrefetchLinesQ  (farPrefetchLinesQ),
    .farPrefetchEnQ     (farPrefetchEnQ),
    .externalLlcQ       (externalLlcQ)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic giveVerdict();
    $display("Checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  // Request is held across exactly one rising edge, then dropped
  task automatic access(input logic wr, input cache_policy_pkg::reg_sel_e tgt,
                        input logic [1:0] el, input logic sec,
                        input logic [63:0] wd);
    int n;
    @(negedge clk);
    reqValid  = 1'b1;
    reqWrite  = wr;
    reqTarget = tgt;
    reqEl     = el;
    reqSecure = sec;
    reqWdata  = wd;
    @(negedge clk);
    reqValid = 1'b0;
    reqWrite = 1'b0;
    for (n = 0; n < 4 && ackQ !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (ackQ !== 1'b1) begin
      nErrors++;
      $display("MISMATCH at %0t: no acknowledge", $time);
      giveVerdict();
    end
  endtask

  task automatic checkAck(input logic f, input logic [63:0] d);
    check(faultQ, f, "fault");
    check(rdataQ, d, "read data");
  endtask

  // Decoded outputs trail the register by one more edge
  task automatic wrExt(input logic [63:0] d);
    access(1'b1, cache_policy_pkg::SEL_EXT, cache_policy_pkg::EL1, 1'b0, d);
    @(negedge clk);
  endtask

  task automatic applyReset(input int cycles);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (cycles) @(negedge clk);
    check(externalLlcQ, 1'b0, "llc in reset");
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic resetDefaults();
    check(l3StreamThreshQ, cache_policy_pkg::L3_T1, "l3 thr");
    check(l2StreamThreshQ, cache_policy_pkg::L2_T1, "l2 thr");
    check(l1StreamThreshQ, cache_policy_pkg::L1_T0, "l1 thr");
    check(nearPrefetchLimitQ, 3'h5, "limit");
    check(farPrefetchLinesQ, 6'h08, "far lines");
    check(flushAllocL3Q, 1'b1, "alloc");
    check(flushEvictNotifyQ, 1'b0, "evict");
    check(externalLlcQ, 1'b0, "llc");
    access(1'b0, cache_policy_pkg::SEL_EXT, cache_policy_pkg::EL1, 1'b0, 0);
    checkAck(1'b0, cache_policy_pkg::EXT_RESET);
    access(1'b0, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL3, 1'b1, 0);
    checkAck(1'b0, cache_policy_pkg::AUX_RESET);
    $display("Test resetDefaults done");
  endtask

  task automatic cfgTest();
    access(1'b0, cache_policy_pkg::SEL_CFG, cache_policy_pkg::EL1, 1'b0, 0);
    checkAck(1'b0, {61'h0, cache_policy_pkg::SCU_PRESENT,
                    cache_policy_pkg::ECC_ABSENT});
    access(1'b1, cache_policy_pkg::SEL_CFG, cache_policy_pkg::EL3, 1'b1,
           64'hffff_ffff_ffff_ffff);
    checkAck(1'b1, 64'h0);
    access(1'b0, cache_policy_pkg::SEL_CFG, cache_policy_pkg::EL0, 1'b0, 0);
    checkAck(1'b1, 64'h0);
    $display("Test cfgTest done");
  endtask

  task automatic auxTest();
    access(1'b1, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL3, 1'b1,
           64'h1234_5678_9abc_def0);
    checkAck(1'b0, 64'h0);
    access(1'b0, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL1, 1'b0, 0);
    checkAck(1'b0, 64'h1234_5678_9abc_def0);
    el3AuxBit = 1'b0;
    access(1'b1, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL2, 1'b0,
           64'h0f0f_0f0f_0f0f_0f0f);
    checkAck(1'b1, 64'h0);
    el3AuxBit = 1'b1;
    access(1'b1, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL1, 1'b0,
           64'h0f0f_0f0f_0f0f_0f0f);
    checkAck(1'b1, 64'h0);
    access(1'b0, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL1, 1'b1, 0);
    checkAck(1'b0, 64'h1234_5678_9abc_def0);
    access(1'b1, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL1, 1'b1,
           64'h0f0f_0f0f_0f0f_0f0f);
    checkAck(1'b0, 64'h0);
    el2AuxBit = 1'b1;
    access(1'b1, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL1, 1'b0,
           64'h5555_aaaa_5555_aaaa);
    checkAck(1'b0, 64'h0);
    access(1'b0, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL2, 1'b0, 0);
    checkAck(1'b0, 64'h5555_aaaa_5555_aaaa);
    $display("Test auxTest done");
  endtask

  task automatic extTest();
    wrExt(64'hffff_ffff_ffff_ffff);
    check(l3StreamEnQ, 1'b0, "l3 en");
    check(l2StreamEnQ, 1'b0, "l2 en");
    check(l1StreamEnQ, 1'b0, "l1 en");
    check(nearPrefetchLimitQ, 3'h7, "limit");
    check(flushSupplyDataQ, 1'b0, "supply");
    check(flushEvictNotifyQ, 1'b1, "evict");
    check(externalLlcQ, 1'b1, "llc");
    access(1'b0, cache_policy_pkg::SEL_EXT, cache_policy_pkg::EL2, 1'b0, 0);
    checkAck(1'b0, cache_policy_pkg::EXT_WR_MASK);
    wrExt(64'hffff_ff10_9200_0000);
    check(l3StreamThreshQ, cache_policy_pkg::L3_T0, "l3 thr");
    check(l2StreamThreshQ, cache_policy_pkg::L2_T2, "l2 thr");
    check(l1StreamThreshQ, cache_policy_pkg::L1_T1, "l1 thr");
    check(farPrefetchLinesQ, 6'h10, "far 16");
    check(nearPrefetchLimitQ, 3'h0, "limit");
    check(flushAllocL3Q, 1'b1, "alloc");
    access(1'b0, cache_policy_pkg::SEL_EXT, cache_policy_pkg::EL3, 1'b1, 0);
    checkAck(1'b0, 64'h0000_0000_1200_0000);
    wrExt(64'h0000_0000_4400_1400);
    check(l3StreamThreshQ, cache_policy_pkg::L3_T2, "l3 thr");
    check(l2StreamThreshQ, cache_policy_pkg::L2_T0, "l2 thr");
    check(l1StreamThreshQ, cache_policy_pkg::L1_T2, "l1 thr");
    check(farPrefetchLinesQ, 6'h02, "far 2");
    wrExt(64'h0000_0000_0000_1800);
    check(farPrefetchLinesQ, 6'h04, "far 4");
    wrExt(64'h0000_0000_0000_1000);
    check(farPrefetchEnQ, 1'b0, "far off");
    wrExt(64'h0000_0000_0600_0800);
    check(l1StreamEnQ, 1'b0, "l1 off");
    access(1'b0, cache_policy_pkg::SEL_EXT, cache_policy_pkg::EL1, 1'b0, 0);
    checkAck(1'b0, 64'h0000_0000_0600_1000);
    $display("Test extTest done");
  endtask

  task automatic atomQuery(input logic ld, input logic hit, input logic exp);
    @(negedge clk);
    atomReq       = 1'b1;
    atomLoad      = ld;
    atomHitUnique = hit;
    @(negedge clk);
    atomReq = 1'b0;
    check(atomDoneQ, 1'b1, "atomic_placement done");
    check(atomNearQ, exp, "atomic_placement near");
  endtask

  task automatic atomTest();
    wrExt(64'h0);
    atomQuery(1'b0, 1'b1, 1'b1);
    atomQuery(1'b1, 1'b0, 1'b0);
    wrExt(64'h0000_0040_0000_0000);
    atomQuery(1'b0, 1'b0, 1'b1);
    wrExt(64'h0000_0080_0000_0000);
    atomQuery(1'b1, 1'b1, 1'b0);
    wrExt(64'h0000_00c0_0000_0000);
    atomQuery(1'b1, 1'b0, 1'b1);
    atomQuery(1'b0, 1'b0, 1'b0);
    atomQuery(1'b0, 1'b1, 1'b1);
    $display("Test atomTest done");
  endtask

  task automatic midReset();
    wrExt(64'h0000_0000_0000_0001);
    applyReset(3);
    check(externalLlcQ, 1'b0, "llc after reset");
    access(1'b0, cache_policy_pkg::SEL_EXT, cache_policy_pkg::EL1, 1'b0, 0);
    checkAck(1'b0, cache_policy_pkg::EXT_RESET);
    access(1'b0, cache_policy_pkg::SEL_AUX, cache_policy_pkg::EL3, 1'b1, 0);
    checkAck(1'b0, cache_policy_pkg::AUX_RESET);
    $display("Test midReset done");
  endtask

  initial begin
    nErrors       = 0;
    checkCount    = 0;
    rst_b         = 1'b0;
    reqValid      = 1'b0;
    reqWrite      = 1'b0;
    reqTarget     = cache_policy_pkg::SEL_AUX;
    reqEl         = cache_policy_pkg::EL1;
    reqSecure     = 1'b0;
    reqWdata      = 64'h0;
    el2AuxBit     = 1'b0;
    el3AuxBit     = 1'b1;
    atomReq       = 1'b0;
    atomLoad      = 1'b0;
    atomHitUnique = 1'b0;
    applyReset(8);
    resetDefaults();
    cfgTest();
    auxTest();
    extTest();
    atomTest();
    midReset();
    giveVerdict();
  end
endmodule
